// file: inc/del_pkg.sv
`default_nettype none
package del_pkg;
    // Status word layout.
    localparam int          STA_W        = 32;
    localparam int          STA_PRESENT  = 0;
    localparam int          STA_ENABLED  = 1;
    localparam int          STA_SHOWN    = 2;
    localparam int          STA_FUNC     = 3;
    localparam logic [31:0] STA_RESET    = 32'h0000_0000;
    localparam logic [31:0] STA_MECH_ERR = 32'h0000_0003;
    // Request arguments.
    localparam logic        ARG_ENABLE   = 1'h1;
    localparam logic        ARG_CANCEL   = 1'h0;
    // Sleep states.
    localparam logic [2:0]  SLEEP_S0     = 3'h0;
    localparam logic [2:0]  SLEEP_S4     = 3'h4;
    localparam logic [2:0]  SLEEP_S5     = 3'h5;
    // Mechanism timeouts and default dependent count.
    localparam int          MECH_TIMEOUT_US = 400;
    localparam int          CLK_MHZ         = 10;
    localparam int          MECH_TIMEOUT_CYC = MECH_TIMEOUT_US * CLK_MHZ;
    localparam int          NUM_DEP_DEFAULT  = 4;
    // Controller states, one-hot.
    typedef enum logic [4:0] {
        ST_IDLE   = 5'h01,
        ST_HOT    = 5'h02,
        ST_ARMED  = 5'h04,
        ST_WARM   = 5'h08,
        ST_LOCK   = 5'h10
    } del_state_t;
endpackage
`default_nettype wire

// file: src/del_eject_ctrl.sv
`timescale 1ns/100ps
`default_nettype none
// Function
// - A hot eject runs the motor at once and is acknowledged when done.
// - A warm eject request for sleep state five (ALT_STATE) only arms; states one to four are refused.
// - An armed eject runs only once sleep is enabled in the armed state.
// - One ejects or arms, zero cancels an armed eject, never a hot one.
// - One locks, zero unlocks, and a lock is acknowledged once locked.
// - A device has either the lock or the eject mechanism, never both.
// - Status bits are present, enabled, shown and functioning, rest 0.
// - A clear present bit forces the enabled bit clear.
// - Resources are decoded only while present and enabled are set.
// - Ejecting the parent notifies and ejects every dependent device.
// - Dependents have no eject mechanism and go with the parent.
// - A bare removable device advertises a removable indication.
// - A mechanical failure makes the status word read three.
module del_eject_ctrl
    import del_pkg::*;
#(
    parameter bit         HAS_EJECT  = 1'b1,
    parameter bit         HAS_LOCK   = 1'b0,
    parameter bit         REMOVABLE  = 1'b1,
    parameter logic [2:0] PREF_STATE = 3'h0,
    parameter logic [2:0] ALT_STATE  = 3'h5,
    parameter int         NUM_DEP    = NUM_DEP_DEFAULT,
    parameter int         TIMEOUT    = MECH_TIMEOUT_CYC
) (
    // Clock and reset
    input  wire logic               clk,
    input  wire logic               reset_n,
    // Eject request
    input  wire logic               eject_request,
    input  wire logic [2:0]         eject_state,
    input  wire logic               eject_arg,
    output logic                    eject_done,
    // Lock request
    input  wire logic               lock_request,
    input  wire logic               lock_arg,
    output logic                    lock_done,
    // Sleep entry
    input  wire logic               sleep_enable_control,
    input  wire logic [2:0]         sleep_type,
    // Mechanism
    output logic                    eject_motor,
    input  wire logic               eject_complete,
    output logic                    lock_motor,
    input  wire logic               lock_complete,
    input  wire logic               lock_released,
    // Presence and health
    input  wire logic               device_present,
    input  wire logic               enable_request,
    input  wire logic               show_in_ui,
    input  wire logic               diag_fail,
    // Dependents
    input  wire logic [NUM_DEP-1:0] eject_dependency,
    output logic [NUM_DEP-1:0]      eject_notify,
    // Status
    output logic [STA_W-1:0]        device_status_word,
    output logic                    resource_decode,
    output logic                    removable_indication,
    output logic                    eject_armed
);
    del_state_t  st_r, st_nxt;
    logic [2:0]  arm_st_r, arm_st_nxt;
    logic        fail_r, fail_nxt;
    logic        locked_r, locked_nxt;
    logic        done_nxt, ldone_nxt;
    logic [STA_W-1:0] sta_nxt;
    logic        run, expired;
    logic        st_ok, mech_end, pres, en;

    // A third state or a middle deep state is refused outright.
    assign st_ok = HAS_EJECT && !HAS_LOCK
                && (eject_state == PREF_STATE || eject_state == ALT_STATE)
                && (eject_state <= SLEEP_S5);
    assign run      = (st_r == ST_HOT) || (st_r == ST_WARM) || (st_r == ST_LOCK);
    assign mech_end = eject_complete || expired;

    del_mech_timer #(.LIMIT(TIMEOUT)) u_timer (
        .clk     (clk),
        .reset_n (reset_n),
        .run     (run),
        .expired (expired)
    );

    always_comb begin
        st_nxt     = st_r;
        arm_st_nxt = arm_st_r;
        fail_nxt   = fail_r;
        locked_nxt = locked_r;
        done_nxt   = 1'b0;
        ldone_nxt  = 1'b0;
        case (st_r)
            ST_IDLE: begin
                if (eject_request && st_ok && eject_arg == ARG_ENABLE) begin
                    if (eject_state == SLEEP_S0) begin
                        st_nxt = ST_HOT;
                    end else begin
                        arm_st_nxt = eject_state;
                        st_nxt     = ST_ARMED;
                        done_nxt   = 1'b1;
                    end
                end else if (eject_request) begin
                    done_nxt = 1'b1;
                end else if (lock_request && HAS_LOCK && !HAS_EJECT) begin
                    if (lock_arg == ARG_ENABLE) begin
                        st_nxt = ST_LOCK;
                    end else begin
                        locked_nxt = 1'b0;
                        ldone_nxt  = 1'b1;
                    end
                end else if (lock_request) begin
                    ldone_nxt = 1'b1;
                end
            end
            ST_HOT: begin
                if (mech_end) begin
                    fail_nxt = expired && !eject_complete;
                    done_nxt = 1'b1;
                    st_nxt   = ST_IDLE;
                end
            end
            ST_ARMED: begin
                if (eject_request && eject_arg == ARG_CANCEL) begin
                    st_nxt   = ST_IDLE;
                    done_nxt = 1'b1;
                end else if (sleep_enable_control
                             && sleep_type == arm_st_r) begin
                    st_nxt = ST_WARM;
                end
            end
            ST_WARM: begin
                if (mech_end) begin
                    fail_nxt = expired && !eject_complete;
                    st_nxt   = ST_IDLE;
                end
            end
            ST_LOCK: begin
                if (lock_complete || expired) begin
                    locked_nxt = lock_complete;
                    fail_nxt   = !lock_complete;
                    ldone_nxt  = 1'b1;
                    st_nxt     = ST_IDLE;
                end
            end
            default: st_nxt = ST_IDLE;
        endcase
        // Clearing only from idle lets a failure that ends a run win.
        if (!device_present && st_r == ST_IDLE) begin
            fail_nxt = 1'b0;
        end
        pres = device_present;
        en   = pres && enable_request;
        sta_nxt = STA_RESET;
        sta_nxt[STA_PRESENT] = pres;
        sta_nxt[STA_ENABLED] = en;
        sta_nxt[STA_SHOWN]   = pres && show_in_ui;
        sta_nxt[STA_FUNC]    = pres && !diag_fail && !fail_r;
        if (pres && fail_r) begin
            sta_nxt = STA_MECH_ERR;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            st_r                 <= ST_IDLE;
            arm_st_r             <= SLEEP_S0;
            fail_r               <= 1'b0;
            locked_r             <= 1'b0;
            eject_done           <= 1'b0;
            lock_done            <= 1'b0;
            eject_motor          <= 1'b0;
            lock_motor           <= 1'b0;
            eject_notify         <= '0;
            device_status_word   <= STA_RESET;
            resource_decode      <= 1'b0;
            removable_indication <= 1'b0;
            eject_armed          <= 1'b0;
        end else begin
            st_r               <= st_nxt;
            arm_st_r           <= arm_st_nxt;
            fail_r             <= fail_nxt;
            locked_r           <= locked_nxt;
            eject_done         <= done_nxt;
            lock_done          <= ldone_nxt;
            eject_motor        <= (st_nxt == ST_HOT) || (st_nxt == ST_WARM);
            lock_motor         <= (st_nxt == ST_LOCK) && !lock_released;
            // Dependents follow the parent motor; they own no mechanism.
            eject_notify       <= ((st_nxt == ST_HOT) || (st_nxt == ST_WARM))
                                  ? eject_dependency : '0;
            device_status_word <= sta_nxt;
            resource_decode    <= sta_nxt[STA_PRESENT]
                                  && sta_nxt[STA_ENABLED];
            removable_indication <= REMOVABLE && !HAS_LOCK
                                    && !HAS_EJECT;
            eject_armed        <= (st_nxt == ST_ARMED);
        end
    end

    property p_decode;
        @(posedge clk) disable iff (!reset_n)
        resource_decode |-> device_status_word[STA_PRESENT]
                            && device_status_word[STA_ENABLED];
    endproperty
    a_decode: assert property (p_decode) else $error("decode bad");

    property p_absent;
        @(posedge clk) disable iff (!reset_n)
        !device_status_word[STA_PRESENT] |-> !device_status_word[STA_ENABLED];
    endproperty
    a_absent: assert property (p_absent) else $error("absent enabled");

    property p_resv;
        @(posedge clk) disable iff (!reset_n)
        device_status_word[31:4] == 28'h0000000;
    endproperty
    a_resv: assert property (p_resv) else $error("reserved set");

    property p_hot_done;
        @(posedge clk) disable iff (!reset_n)
        (st_r == ST_HOT) |-> !eject_done;
    endproperty
    a_hot_done: assert property (p_hot_done) else $error("early done");

    sequence s_armed_idle;
        (st_r == ST_ARMED) && !sleep_enable_control;
    endsequence
    property p_warm_wait;
        @(posedge clk) disable iff (!reset_n)
        s_armed_idle |=> !eject_motor;
    endproperty
    a_warm_wait: assert property (p_warm_wait)
        else $error("early warm");

    property p_lock_done;
        @(posedge clk) disable iff (!reset_n)
        (st_r == ST_LOCK && lock_complete) |=> lock_done && locked_r;
    endproperty
    a_lock_done: assert property (p_lock_done) else $error("lock ack");

    property p_notify;
        @(posedge clk) disable iff (!reset_n)
        eject_motor |-> eject_notify == eject_dependency
                        || $changed(eject_dependency);
    endproperty
    a_notify: assert property (p_notify) else $error("notify");

    property p_fail;
        @(posedge clk) disable iff (!reset_n)
        (st_r == ST_HOT && expired && !eject_complete && device_present)
        |=> ##1 device_status_word == STA_MECH_ERR;
    endproperty
    a_fail: assert property (p_fail) else $error("no fail code");
endmodule
`default_nettype wire

// file: src/del_mech_timer.sv
`timescale 1ns/100ps
`default_nettype none
// Counts while a motor operation runs and flags a stuck mechanism.
module del_mech_timer
    import del_pkg::*;
#(
    parameter int LIMIT = MECH_TIMEOUT_CYC
) (
    // Clock and reset
    input  wire logic clk,
    input  wire logic reset_n,
    // Control
    input  wire logic run,
    output logic      expired
);
    logic [15:0] cnt_r;
    logic [15:0] cnt_nxt;
    logic        exp_nxt;

    always_comb begin
        cnt_nxt = 16'h0000;
        exp_nxt = 1'b0;
        if (run) begin
            if (cnt_r == LIMIT[15:0] - 16'h0001) begin
                cnt_nxt = cnt_r;
                exp_nxt = 1'b1;
            end else begin
                cnt_nxt = cnt_r + 16'h0001;
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cnt_r   <= 16'h0000;
            expired <= 1'b0;
        end else begin
            cnt_r   <= cnt_nxt;
            expired <= exp_nxt;
        end
    end
endmodule
`default_nettype wire

// file: test/test_device_eject_lock_status.sv
`timescale 1ns/100ps
`default_nettype none
module test_device_eject_lock_status;
    import del_pkg::*;
    logic        clk, reset_n, eject_request, eject_arg, eject_done;
    logic        lock_request, lock_arg, lock_done, sleep_enable_control;
    logic        eject_motor, eject_complete, lock_motor, lock_complete;
    logic        lock_released, device_present, enable_request, show_in_ui;
    logic        diag_fail, resource_decode, removable_indication;
    logic        eject_armed, lk_done, lk_motor, rm_rmv;
    logic [2:0]  eject_state, sleep_type;
    logic [3:0]  eject_dependency, eject_notify;
    logic [31:0] device_status_word, exp, mask;
    int          bad_count, checks_done, cyc;

    // A short timeout keeps the stuck-mechanism case brief.
    del_eject_ctrl #(.NUM_DEP(4), .TIMEOUT(20)) dut_u (
        .clk(clk), .reset_n(reset_n),
        .eject_request(eject_request), .eject_state(eject_state),
        .eject_arg(eject_arg), .eject_done(eject_done),
        .lock_request(lock_request), .lock_arg(lock_arg),
        .lock_done(lock_done),
        .sleep_enable_control(sleep_enable_control),
        .sleep_type(sleep_type), .eject_motor(eject_motor),
        .eject_complete(eject_complete), .lock_motor(lock_motor),
        .lock_complete(lock_complete), .lock_released(lock_released),
        .device_present(device_present), .enable_request(enable_request),
        .show_in_ui(show_in_ui), .diag_fail(diag_fail),
        .eject_dependency(eject_dependency), .eject_notify(eject_notify),
        .device_status_word(device_status_word),
        .resource_decode(resource_decode),
        .removable_indication(removable_indication),
        .eject_armed(eject_armed));

    // Lock-only and bare variants share the stimulus of the eject device.
    del_eject_ctrl #(.HAS_EJECT(1'b0), .HAS_LOCK(1'b1),
                     .TIMEOUT(20)) lock_u (
        .clk(clk), .reset_n(reset_n),
        .eject_request(eject_request), .eject_state(eject_state),
        .eject_arg(eject_arg), .eject_done(),
        .lock_request(lock_request), .lock_arg(lock_arg),
        .lock_done(lk_done),
        .sleep_enable_control(sleep_enable_control),
        .sleep_type(sleep_type), .eject_motor(),
        .eject_complete(eject_complete), .lock_motor(lk_motor),
        .lock_complete(lock_complete), .lock_released(lock_released),
        .device_present(device_present), .enable_request(enable_request),
        .show_in_ui(show_in_ui), .diag_fail(diag_fail),
        .eject_dependency(eject_dependency), .eject_notify(),
        .device_status_word(), .resource_decode(),
        .removable_indication(), .eject_armed());

    del_eject_ctrl #(.HAS_EJECT(1'b0), .HAS_LOCK(1'b0)) rmv_u (
        .clk(clk), .reset_n(reset_n),
        .eject_request(eject_request), .eject_state(eject_state),
        .eject_arg(eject_arg), .eject_done(),
        .lock_request(lock_request), .lock_arg(lock_arg),
        .lock_done(),
        .sleep_enable_control(sleep_enable_control),
        .sleep_type(sleep_type), .eject_motor(),
        .eject_complete(eject_complete), .lock_motor(),
        .lock_complete(lock_complete), .lock_released(lock_released),
        .device_present(device_present), .enable_request(enable_request),
        .show_in_ui(show_in_ui), .diag_fail(diag_fail),
        .eject_dependency(eject_dependency), .eject_notify(),
        .device_status_word(), .resource_decode(),
        .removable_indication(rm_rmv), .eject_armed());

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task chk(input string name, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", name, e, g);
        end
    endtask

    task results;
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // Requests are raised and dropped at falling edges only.
    task req_eject(input logic [2:0] st, input logic arg);
        eject_state   = st;
        eject_arg     = arg;
        eject_request = 1'b1;
        @(negedge clk);
        eject_request = 1'b0;
    endtask

    task wait_ack(input logic sel, input int lim);
        int i;
        i = 0;
        while (((sel ? lock_done : eject_done) !== 1'b1) && i < lim) begin
            @(negedge clk);
            i++;
        end
    endtask

    always @(posedge clk) begin
        cyc++;
        if (cyc >= 5000) begin
            bad_count++;
            results();
        end
    end

    initial begin
        {eject_request, eject_arg, lock_request, lock_arg} = 4'h0;
        {sleep_enable_control, eject_complete, lock_complete} = 3'h0;
        {device_present, enable_request, show_in_ui} = 3'h7;
        {diag_fail, lock_released} = 2'h0;
        eject_state = 3'h0;
        sleep_type = 3'h0;
        eject_dependency = 4'hA;
        reset_n = 1'b0;
        repeat (5) @(negedge clk);
        chk("status_in_reset", 32'h0, device_status_word);
        reset_n = 1'b1;
        repeat (2) @(negedge clk);
        chk("removable", 32'h0, removable_indication);
        chk("removable_bare", 32'h1, rm_rmv);
        for (int k = 0; k < 16; k++) begin
            {device_present, enable_request, show_in_ui, diag_fail} = k[3:0];
            repeat (2) @(negedge clk);
            exp = {28'h0, ~k[0], k[1], k[3] & k[2], k[3]};
            mask = k[3] ? 32'hFFFF_FFFF : 32'hFFFF_FFF3;
            chk("status", exp & mask, device_status_word & mask);
            chk("decode", {31'h0, k[3] & k[2]}, resource_decode);
        end
        diag_fail = 1'b0;
        $display("test status done");
        req_eject(SLEEP_S0, ARG_ENABLE);
        @(negedge clk);
        chk("hot_motor", 32'h1, eject_motor);
        chk("notify", 32'hA, eject_notify);
        repeat (3) @(negedge clk);
        chk("early_done", 32'h0, eject_done);
        eject_complete = 1'b1;
        wait_ack(1'b0, 10);
        chk("hot_done", 32'h1, eject_done);
        eject_complete = 1'b0;
        @(negedge clk);
        chk("hot_motor_off", 32'h0, eject_motor);
        chk("status_ok", 32'hF, device_status_word);
        $display("test hot eject done");
        req_eject(SLEEP_S5, ARG_ENABLE);
        wait_ack(1'b0, 5);
        chk("arm_done", 32'h1, eject_done);
        @(negedge clk);
        chk("armed", 32'h1, eject_armed);
        chk("arm_motor", 32'h0, eject_motor);
        sleep_type = SLEEP_S4;
        sleep_enable_control = 1'b1;
        repeat (3) @(negedge clk);
        chk("wrong_state_motor", 32'h0, eject_motor);
        sleep_type = SLEEP_S5;
        repeat (2) @(negedge clk);
        chk("warm_motor", 32'h1, eject_motor);
        chk("armed_clear", 32'h0, eject_armed);
        chk("warm_notify", 32'hA, eject_notify);
        eject_complete = 1'b1;
        repeat (2) @(negedge clk);
        {eject_complete, sleep_enable_control} = 2'h0;
        chk("warm_motor_off", 32'h0, eject_motor);
        chk("warm_status", 32'hF, device_status_word);
        $display("test warm eject done");
        req_eject(SLEEP_S5, ARG_ENABLE);
        wait_ack(1'b0, 5);
        @(negedge clk);
        req_eject(SLEEP_S5, ARG_CANCEL);
        wait_ack(1'b0, 5);
        chk("cancel_done", 32'h1, eject_done);
        @(negedge clk);
        chk("cancel_armed", 32'h0, eject_armed);
        sleep_enable_control = 1'b1;
        repeat (3) @(negedge clk);
        chk("cancel_motor", 32'h0, eject_motor);
        sleep_enable_control = 1'b0;
        $display("test cancel done");
        for (int s = 1; s < 5; s++) begin
            @(negedge clk);
            req_eject(s[2:0], ARG_ENABLE);
            wait_ack(1'b0, 5);
            chk("refuse_done", 32'h1, eject_done);
            @(negedge clk);
            chk("refuse_arm", 32'h0, eject_armed);
            chk("refuse_motor", 32'h0, eject_motor);
        end
        $display("test refused states done");
        req_eject(SLEEP_S0, ARG_ENABLE);
        wait_ack(1'b0, 40);
        chk("timeout_done", 32'h1, eject_done);
        repeat (2) @(negedge clk);
        chk("mech_fail", STA_MECH_ERR, device_status_word);
        device_present = 1'b0;
        repeat (2) @(negedge clk);
        chk("absent", 32'h0, device_status_word & 32'hFFFF_FFF3);
        chk("absent_decode", 32'h0, resource_decode);
        device_present = 1'b1;
        repeat (2) @(negedge clk);
        chk("fail_cleared", 32'hF, device_status_word);
        $display("test mechanical failure done");
        lock_arg = ARG_ENABLE;
        lock_request = 1'b1;
        @(negedge clk);
        lock_request = 1'b0;
        repeat (3) @(negedge clk);
        chk("lk_motor", 32'h1, lk_motor);
        chk("lk_early", 32'h0, lk_done);
        lock_complete = 1'b1;
        @(negedge clk);
        chk("lk_done", 32'h1, lk_done);
        lock_complete = 1'b0;
        @(negedge clk);
        chk("lk_motor_off", 32'h0, lk_motor);
        lock_arg = ARG_CANCEL;
        lock_request = 1'b1;
        @(negedge clk);
        lock_request = 1'b0;
        chk("unlock_done", 32'h1, lk_done);
        @(negedge clk);
        $display("test lock done");
        for (int a = 1; a >= 0; a--) begin
            lock_arg = a[0];
            lock_request = 1'b1;
            @(negedge clk);
            lock_request = 1'b0;
            wait_ack(1'b1, 10);
            chk("lock_done", 32'h1, lock_done);
            chk("lock_motor", 32'h0, lock_motor);
            @(negedge clk);
        end
        $display("test lock refusal done");
        results();
    end
endmodule
`default_nettype wire
